// File: hw/csi_pkg.sv
// Shared constants for the current sensor two-wire target and its controller.
// Assumes a 100 MHz system clock on both ends.
package csi_pkg;
	// Target address: fixed upper bits, pin-selected lower bits
	localparam logic [2:0] ADDR_FIXED = 3'h6;
	// Internal register pointers
	localparam logic [7:0] REG_DATA = 8'h00;
	localparam logic [7:0] REG_CTRL = 8'h01;
	// Data register fields
	localparam int DATA_MAG_LSB = 0;
	localparam int DATA_NEW_BIT = 9;
	localparam int DATA_LATCH_BIT = 10;
	localparam int DATA_LIVE_BIT = 11;
	// Control register fields
	localparam int CTRL_RANGE_LSB = 0;
	localparam int CTRL_THR_LSB = 2;
	localparam int CTRL_AVG_LSB = 6;
	localparam int CTRL_CLR_BIT = 14;
	// Control reset values
	localparam logic [1:0] RANGE_RST = 2'h0;
	localparam logic [3:0] THR_RST = 4'h0;
	localparam logic [7:0] AVG_RST = 8'h00;
	// Byte framing
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [1:0] LAST_BYTE = 2'h2;
	// Controller register map and fields
	localparam logic [3:0] AXI_CMD_OFS = 4'h0;
	localparam logic [3:0] AXI_STAT_OFS = 4'h4;
	localparam logic [1:0] OP_START = 2'h0;
	localparam logic [1:0] OP_STOP = 2'h1;
	localparam logic [1:0] OP_WRITE = 2'h2;
	localparam logic [1:0] OP_READ = 2'h3;
	localparam int CMD_DATA_LSB = 8;
	localparam int CMD_ACK_BIT = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Serial clock timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCL_PERIOD_NS = 2500;
	localparam int QUARTER_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
endpackage

// File: hw/csi_if.sv
// Two-wire bus between the sensor target and the bus controller.
// Both lines are open drain with a pull-up; a line is low while any enable drives it.
`timescale 1ns/1ns
interface csi_if;
	logic scl_out;
	logic scl_oe;
	logic ctl_sda_out;
	logic ctl_sda_oe;
	logic tgt_sda_out;
	logic tgt_sda_oe;
	logic scl;
	logic sda;

	// Wired-AND of all drivers
	assign scl = !(scl_oe && !scl_out);
	assign sda = !((ctl_sda_oe && !ctl_sda_out) || (tgt_sda_oe && !tgt_sda_out));

	modport target (input scl, input sda, output tgt_sda_out, output tgt_sda_oe);
	modport controller (input scl, input sda, output scl_out, output scl_oe,
		output ctl_sda_out, output ctl_sda_oe);
endinterface

// File: hw/csi_target.sv
// Sensor side of the two-wire bus: framing, address match, 24-bit registers.
// Assumes the controller makes the serial clock; pins are synchronised here.
// Summary of operation
// - Sixteen addresses chosen by two select pins
// - Start is data falling while clock high
// - Stop is data rising while clock high
// - Address byte: seven bits, direction, acknowledge
// - Data bytes: eight bits plus acknowledge, repeating
// - Data changes only while clock low
// - Start or stop aborts and restarts sequencing
// - Direction zero writes, one reads
// - Matching address acknowledged on ninth clock
// - Every written byte acknowledged low
// - Controller releases data before ninth clock
// - Controller clocks; target drives open drain
// - Reads return magnitude and three flags
// - Writes set range, threshold, averaging, clear
// - First written data byte is register pointer
// - Registers are three bytes wide
// - Further triplets go to next register
// - Read uses pointer write then repeated start
// - Controller acknowledges, refuses last byte
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ns
module csi_target (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	// Address select straps, each a four-level code
	input wire logic [1:0] ADDR_SELECT_PIN_LOW_IN,
	input wire logic [1:0] ADDR_SELECT_PIN_HIGH_IN,
	// Measurement side
	input wire logic [8:0] CURRENT_IN,
	input wire logic NEW_SAMPLE_IN,
	input wire logic OVERCURRENT_IN,
	// Control outputs
	output logic [1:0] RANGE_OUT,
	output logic [3:0] THRESHOLD_OUT,
	output logic [7:0] AVERAGE_OUT,
	output logic LATCHED_FAULT_OUT,
	// Bus
	csi_if.target bus
);
	typedef enum logic [2:0] {T_IDLE, T_ADDR, T_ADDR_ACK, T_RX, T_RX_ACK, T_TX, T_TX_ACK}
		csi_tstate_type;

	typedef struct packed {
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic [3:0] pin_s0;
		logic [3:0] pin_s1;
		logic [3:0] pin_s2;
		logic scl_f;
		logic sda_f;
		logic [3:0] pin_f;
		csi_tstate_type st;
		logic [3:0] bit_cnt;
		logic [1:0] byte_cnt;
		logic ptr_loaded;
		logic rw;
		logic [7:0] rx_sh;
		logic [23:0] tx_sh;
		logic [15:0] wr_acc;
		logic [7:0] ptr;
		logic sda_oe;
		logic [1:0] range;
		logic [3:0] thr;
		logic [7:0] avg;
		logic latched;
		logic new_data;
	} csi_tgt_type;

	csi_tgt_type cur_ff;
	csi_tgt_type nxt_st;

	// Register read mux; unmapped pointers read as zero
	function automatic logic [23:0] rd_word(input logic [7:0] p, input csi_tgt_type s,
		input logic [8:0] mag, input logic live);
		logic [23:0] w;
		w = 24'h000000;
		if (p == csi_pkg::REG_DATA)
		begin
			w[csi_pkg::DATA_MAG_LSB +: 9] = mag;
			w[csi_pkg::DATA_NEW_BIT] = s.new_data;
			w[csi_pkg::DATA_LATCH_BIT] = s.latched;
			w[csi_pkg::DATA_LIVE_BIT] = live;
		end
		else if (p == csi_pkg::REG_CTRL)
		begin
			w[csi_pkg::CTRL_RANGE_LSB +: 2] = s.range;
			w[csi_pkg::CTRL_THR_LSB +: 4] = s.thr;
			w[csi_pkg::CTRL_AVG_LSB +: 8] = s.avg;
		end
		return w;
	endfunction

	// Next state of the whole target
	always_comb
	begin
		logic scl_n;
		logic sda_n;
		logic rise;
		logic fall;
		logic start;
		logic stop;
		logic clr;
		logic [23:0] word;
		logic [23:0] wdat;
		scl_n = cur_ff.scl_f;
		sda_n = cur_ff.sda_f;
		clr = 1'b0;
		word = 24'h000000;
		wdat = 24'h000000;
		nxt_st = cur_ff;
		// Three-stage synchronisers; a change counts once stages two and three agree
		nxt_st.scl_s = {cur_ff.scl_s[1:0], bus.scl};
		nxt_st.sda_s = {cur_ff.sda_s[1:0], bus.sda};
		nxt_st.pin_s0 = {ADDR_SELECT_PIN_HIGH_IN, ADDR_SELECT_PIN_LOW_IN};
		nxt_st.pin_s1 = cur_ff.pin_s0;
		nxt_st.pin_s2 = cur_ff.pin_s1;
		if (cur_ff.scl_s[1] == cur_ff.scl_s[2])
			scl_n = cur_ff.scl_s[2];
		if (cur_ff.sda_s[1] == cur_ff.sda_s[2])
			sda_n = cur_ff.sda_s[2];
		if (cur_ff.pin_s1 == cur_ff.pin_s2)
			nxt_st.pin_f = cur_ff.pin_s2;
		nxt_st.scl_f = scl_n;
		nxt_st.sda_f = sda_n;
		rise = scl_n && !cur_ff.scl_f;
		fall = !scl_n && cur_ff.scl_f;
		// Data edges only count as conditions while the clock stays high
		start = cur_ff.scl_f && scl_n && cur_ff.sda_f && !sda_n;
		stop = cur_ff.scl_f && scl_n && !cur_ff.sda_f && sda_n;
		if (start)
		begin
			// Abort anything in flight; the pointer survives a repeated start
			nxt_st.st = T_ADDR;
			nxt_st.bit_cnt = 4'h0;
			nxt_st.byte_cnt = 2'h0;
			nxt_st.ptr_loaded = 1'b0;
			nxt_st.sda_oe = 1'b0;
		end
		else if (stop)
		begin
			// A partial triplet is left as it is here; the next start clears byte_cnt and drops it
			nxt_st.st = T_IDLE;
			nxt_st.sda_oe = 1'b0;
		end
		else
		begin
			case (cur_ff.st)
				T_IDLE:
				begin
					nxt_st.sda_oe = 1'b0;
				end
				T_ADDR, T_RX:
				begin
					// Sample on rising clock, act after the eighth bit
					if (rise)
					begin
						nxt_st.rx_sh = {cur_ff.rx_sh[6:0], sda_n};
						nxt_st.bit_cnt = cur_ff.bit_cnt + 4'h1;
					end
					else if (fall && cur_ff.bit_cnt == csi_pkg::ACK_SLOT)
					begin
						if (cur_ff.st == T_RX)
						begin
							nxt_st.sda_oe = 1'b1;
							nxt_st.st = T_RX_ACK;
							if (!cur_ff.ptr_loaded)
							begin
								nxt_st.ptr = cur_ff.rx_sh;
								nxt_st.ptr_loaded = 1'b1;
							end
							else if (cur_ff.byte_cnt == csi_pkg::LAST_BYTE)
							begin
								// Only a full triplet updates a register
								wdat = {cur_ff.wr_acc, cur_ff.rx_sh};
								if (cur_ff.ptr == csi_pkg::REG_CTRL)
								begin
									nxt_st.range = wdat[csi_pkg::CTRL_RANGE_LSB +: 2];
									nxt_st.thr = wdat[csi_pkg::CTRL_THR_LSB +: 4];
									nxt_st.avg = wdat[csi_pkg::CTRL_AVG_LSB +: 8];
									clr = wdat[csi_pkg::CTRL_CLR_BIT];
								end
								nxt_st.ptr = cur_ff.ptr + 8'h01;
								nxt_st.byte_cnt = 2'h0;
							end
							else
							begin
								nxt_st.wr_acc = {cur_ff.wr_acc[7:0], cur_ff.rx_sh};
								nxt_st.byte_cnt = cur_ff.byte_cnt + 2'h1;
							end
						end
						else if (cur_ff.rx_sh[7:1] == {csi_pkg::ADDR_FIXED, cur_ff.pin_f})
						begin
							// Match: pull low through the ninth clock
							nxt_st.sda_oe = 1'b1;
							nxt_st.rw = cur_ff.rx_sh[0];
							nxt_st.st = T_ADDR_ACK;
						end
						else
							nxt_st.st = T_IDLE;
					end
				end
				T_ADDR_ACK, T_RX_ACK:
				begin
					// Leave the slot on the falling edge after the ninth clock
					if (fall)
					begin
						nxt_st.bit_cnt = 4'h0;
						if (cur_ff.st == T_ADDR_ACK && cur_ff.rw)
						begin
							word = rd_word(cur_ff.ptr, cur_ff, CURRENT_IN, OVERCURRENT_IN);
							if (cur_ff.ptr == csi_pkg::REG_DATA)
								nxt_st.new_data = 1'b0;
							nxt_st.sda_oe = !word[23];
							nxt_st.tx_sh = {word[22:0], 1'b0};
							nxt_st.byte_cnt = 2'h0;
							nxt_st.st = T_TX;
						end
						else
						begin
							nxt_st.sda_oe = 1'b0;
							nxt_st.st = T_RX;
						end
					end
				end
				T_TX:
				begin
					// Drive each bit after the falling edge, release for the slot
					if (rise)
						nxt_st.bit_cnt = cur_ff.bit_cnt + 4'h1;
					else if (fall)
					begin
						if (cur_ff.bit_cnt == csi_pkg::ACK_SLOT)
						begin
							nxt_st.sda_oe = 1'b0;
							nxt_st.st = T_TX_ACK;
						end
						else
						begin
							nxt_st.sda_oe = !cur_ff.tx_sh[23];
							nxt_st.tx_sh = {cur_ff.tx_sh[22:0], 1'b0};
						end
					end
				end
				T_TX_ACK:
				begin
					// A refused byte ends the read; wait for the next condition
					if (rise && sda_n)
						nxt_st.st = T_IDLE;
					else if (fall)
					begin
						word = cur_ff.tx_sh;
						nxt_st.byte_cnt = cur_ff.byte_cnt + 2'h1;
						if (cur_ff.byte_cnt == csi_pkg::LAST_BYTE)
						begin
							word = rd_word(cur_ff.ptr + 8'h01, cur_ff, CURRENT_IN, OVERCURRENT_IN);
							if (cur_ff.ptr + 8'h01 == csi_pkg::REG_DATA)
								nxt_st.new_data = 1'b0;
							nxt_st.ptr = cur_ff.ptr + 8'h01;
							nxt_st.byte_cnt = 2'h0;
						end
						nxt_st.sda_oe = !word[23];
						nxt_st.tx_sh = {word[22:0], 1'b0};
						nxt_st.bit_cnt = 4'h0;
						nxt_st.st = T_TX;
					end
				end
				default:
				begin
					nxt_st.st = T_IDLE;
					nxt_st.sda_oe = 1'b0;
				end
			endcase
		end
		// Flags: a set in the same cycle as a clear wins
		nxt_st.latched = OVERCURRENT_IN || (cur_ff.latched && !clr);
		if (NEW_SAMPLE_IN)
			nxt_st.new_data = 1'b1;
	end

	// State register
	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			cur_ff <= '0;
			cur_ff.scl_s <= 3'h7;
			cur_ff.sda_s <= 3'h7;
			cur_ff.scl_f <= 1'b1;
			cur_ff.sda_f <= 1'b1;
			cur_ff.st <= T_IDLE;
			cur_ff.range <= csi_pkg::RANGE_RST;
			cur_ff.thr <= csi_pkg::THR_RST;
			cur_ff.avg <= csi_pkg::AVG_RST;
		end
		else
			cur_ff <= nxt_st;
	end

	// Outputs straight from the state register; open drain only ever pulls low
	assign bus.tgt_sda_out = 1'b0;
	assign bus.tgt_sda_oe = cur_ff.sda_oe;
	assign RANGE_OUT = cur_ff.range;
	assign THRESHOLD_OUT = cur_ff.thr;
	assign AVERAGE_OUT = cur_ff.avg;
	assign LATCHED_FAULT_OUT = cur_ff.latched;
endmodule

// File: hw/csi_ctrl.sv
// Bus controller end: one bus condition or byte per software command.
// Assumes software polls busy over AXI4-Lite before issuing the next command.
`timescale 1ns/1ns
module csi_ctrl (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	// AXI4-Lite write channels
	input wire logic [3:0] AXI_AWADDR_IN,
	input wire logic AXI_AWVALID_IN,
	output logic AXI_AWREADY_OUT,
	input wire logic [31:0] AXI_WDATA_IN,
	input wire logic [3:0] AXI_WSTRB_IN,
	input wire logic AXI_WVALID_IN,
	output logic AXI_WREADY_OUT,
	output logic [1:0] AXI_BRESP_OUT,
	output logic AXI_BVALID_OUT,
	input wire logic AXI_BREADY_IN,
	// AXI4-Lite read channels
	input wire logic [3:0] AXI_ARADDR_IN,
	input wire logic AXI_ARVALID_IN,
	output logic AXI_ARREADY_OUT,
	output logic [31:0] AXI_RDATA_OUT,
	output logic [1:0] AXI_RRESP_OUT,
	output logic AXI_RVALID_OUT,
	input wire logic AXI_RREADY_IN,
	// Bus
	csi_if.controller bus
);
	typedef enum logic [1:0] {C_IDLE, C_START, C_STOP, C_BITS} csi_cstate_type;

	typedef struct packed {
		logic aw_got;
		logic [3:0] awaddr;
		logic w_got;
		logic [31:0] wdata;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [2:0] sda_s;
		logic sda_f;
		logic [6:0] div;
		csi_cstate_type st;
		logic [1:0] q;
		logic [3:0] bit_i;
		logic [7:0] tx;
		logic ack_bit;
		logic [7:0] rx;
		logic nak;
		logic scl_oe;
		logic sda_oe;
	} csi_ctl_type;

	localparam logic [6:0] QUARTER_LAST = 7'(csi_pkg::QUARTER_CYC - 1);

	csi_ctl_type cur_ff;
	csi_ctl_type nxt_st;

	// Next state of the controller
	always_comb
	begin
		logic tick;
		logic busy;
		logic [31:0] stat;
		nxt_st = cur_ff;
		busy = cur_ff.st != C_IDLE;
		stat = {16'h0000, cur_ff.rx, 6'h00, cur_ff.nak, busy};
		// Data line synchroniser with agreement filter
		nxt_st.sda_s = {cur_ff.sda_s[1:0], bus.sda};
		if (cur_ff.sda_s[1] == cur_ff.sda_s[2])
			nxt_st.sda_f = cur_ff.sda_s[2];
		// Address and data are taken in either order
		if (AXI_AWVALID_IN && cur_ff.awready)
		begin
			nxt_st.aw_got = 1'b1;
			nxt_st.awaddr = AXI_AWADDR_IN;
		end
		if (AXI_WVALID_IN && cur_ff.wready)
		begin
			nxt_st.w_got = 1'b1;
			nxt_st.wdata = AXI_WDATA_IN;
		end
		if (AXI_BREADY_IN && cur_ff.bvalid)
			nxt_st.bvalid = 1'b0;
		if (cur_ff.aw_got && cur_ff.w_got)
		begin
			// Commands arriving while busy are dropped; at least one byte lane must be strobed
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = csi_pkg::RESP_OKAY;
			if (cur_ff.awaddr == csi_pkg::AXI_CMD_OFS)
			begin
				if (!busy && AXI_WSTRB_IN != 4'h0)
				begin
					nxt_st.q = 2'h0;
					nxt_st.bit_i = 4'h0;
					nxt_st.div = 7'h00;
					nxt_st.tx = cur_ff.wdata[csi_pkg::CMD_DATA_LSB +: 8];
					nxt_st.ack_bit = cur_ff.wdata[csi_pkg::CMD_ACK_BIT];
					case (cur_ff.wdata[1:0])
						csi_pkg::OP_START: nxt_st.st = C_START;
						csi_pkg::OP_STOP: nxt_st.st = C_STOP;
						csi_pkg::OP_WRITE:
						begin
							// A written byte leaves the acknowledge slot to the target
							nxt_st.st = C_BITS;
							nxt_st.ack_bit = 1'b1;
						end
						default:
						begin
							nxt_st.st = C_BITS;
							nxt_st.tx = 8'hff; // Released bits let the target drive
						end
					endcase
				end
			end
			else if (cur_ff.awaddr != csi_pkg::AXI_STAT_OFS)
				nxt_st.bresp = csi_pkg::RESP_SLVERR;
		end
		nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
		nxt_st.wready = !nxt_st.w_got && !nxt_st.bvalid;
		// Read channel: one cycle after the address is taken
		if (AXI_RREADY_IN && cur_ff.rvalid)
			nxt_st.rvalid = 1'b0;
		if (AXI_ARVALID_IN && cur_ff.arready)
		begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata = 32'h00000000;
			nxt_st.rresp = csi_pkg::RESP_OKAY;
			if (AXI_ARADDR_IN == csi_pkg::AXI_STAT_OFS)
				nxt_st.rdata = stat;
			else if (AXI_ARADDR_IN != csi_pkg::AXI_CMD_OFS)
				nxt_st.rresp = csi_pkg::RESP_SLVERR;
		end
		nxt_st.arready = !nxt_st.rvalid;
		// Quarter-period enable from the divider
		tick = 1'b0;
		if (busy)
		begin
			nxt_st.div = cur_ff.div + 7'h01;
			if (cur_ff.div == QUARTER_LAST)
			begin
				nxt_st.div = 7'h00;
				tick = 1'b1;
			end
		end
		if (tick)
		begin
			nxt_st.q = cur_ff.q + 2'h1;
			case (cur_ff.st)
				C_START:
				begin
					// Release, raise clock, pull data low, pull clock low
					case (cur_ff.q)
						2'h0: nxt_st.sda_oe = 1'b0;
						2'h1: nxt_st.scl_oe = 1'b0;
						2'h2: nxt_st.sda_oe = 1'b1;
						default:
						begin
							nxt_st.scl_oe = 1'b1;
							nxt_st.st = C_IDLE;
						end
					endcase
				end
				C_STOP:
				begin
					case (cur_ff.q)
						2'h0: nxt_st.sda_oe = 1'b1;
						2'h1: nxt_st.scl_oe = 1'b0;
						default:
						begin
							nxt_st.sda_oe = 1'b0;
							nxt_st.st = C_IDLE;
						end
					endcase
				end
				C_BITS:
				begin
					case (cur_ff.q)
						2'h0:
						begin
							// Data moves only while the clock is low
							if (cur_ff.bit_i == csi_pkg::ACK_SLOT)
								nxt_st.sda_oe = !cur_ff.ack_bit;
							else
								nxt_st.sda_oe = !cur_ff.tx[7];
						end
						2'h1: nxt_st.scl_oe = 1'b0;
						2'h2:
						begin
							if (cur_ff.bit_i == csi_pkg::ACK_SLOT)
								nxt_st.nak = cur_ff.sda_f;
							else
							begin
								nxt_st.rx = {cur_ff.rx[6:0], cur_ff.sda_f};
								nxt_st.tx = {cur_ff.tx[6:0], 1'b1};
							end
						end
						default:
						begin
							nxt_st.scl_oe = 1'b1;
							nxt_st.bit_i = cur_ff.bit_i + 4'h1;
							if (cur_ff.bit_i == csi_pkg::ACK_SLOT)
								nxt_st.st = C_IDLE;
						end
					endcase
				end
				default: nxt_st.st = C_IDLE;
			endcase
		end
	end

	// State register
	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			cur_ff <= '0;
			cur_ff.sda_s <= 3'h7;
			cur_ff.sda_f <= 1'b1;
			cur_ff.st <= C_IDLE;
		end
		else
			cur_ff <= nxt_st;
	end

	// Outputs straight from the state register
	assign bus.scl_out = 1'b0;
	assign bus.scl_oe = cur_ff.scl_oe;
	assign bus.ctl_sda_out = 1'b0;
	assign bus.ctl_sda_oe = cur_ff.sda_oe;
	assign AXI_AWREADY_OUT = cur_ff.awready;
	assign AXI_WREADY_OUT = cur_ff.wready;
	assign AXI_BRESP_OUT = cur_ff.bresp;
	assign AXI_BVALID_OUT = cur_ff.bvalid;
	assign AXI_ARREADY_OUT = cur_ff.arready;
	assign AXI_RDATA_OUT = cur_ff.rdata;
	assign AXI_RRESP_OUT = cur_ff.rresp;
	assign AXI_RVALID_OUT = cur_ff.rvalid;
endmodule

// File: dv/csi_monitor.sv
// Checker for the two-wire link between the sensor target and the bus controller.
// Takes the interface wires and the target's address straps as plain inputs.
`timescale 1ns/1ns
module csi_monitor (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	// Target address straps
	input wire logic [1:0] ADDR_SELECT_PIN_LOW_IN,
	input wire logic [1:0] ADDR_SELECT_PIN_HIGH_IN,
	// Link drivers and resolved wires
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic ctl_sda_out,
	input wire logic ctl_sda_oe,
	input wire logic tgt_sda_out,
	input wire logic tgt_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	logic scl_q_ff;
	logic sda_q_ff;
	logic matched_ff;
	logic read_ff;
	logic [3:0] bits_ff;
	logic [1:0] bytes_ff;
	logic [7:0] shift_ff;
	// Conditions seen on the raw wires, one clock of history
	wire logic start_ev = scl && scl_q_ff && sda_q_ff && !sda;
	wire logic stop_ev = scl && scl_q_ff && !sda_q_ff && sda;
	wire logic rise_ev = scl && !scl_q_ff;
	wire logic addr_hit = shift_ff[7:1] == {csi_pkg::ADDR_FIXED, ADDR_SELECT_PIN_HIGH_IN,
		ADDR_SELECT_PIN_LOW_IN};

	// Bit and byte position, tracked independently of the target's own counters
	always_ff @(posedge CLK_IN)
	begin
		scl_q_ff <= scl;
		sda_q_ff <= sda;
		if (!RST_N_IN || start_ev || stop_ev)
		begin
			bits_ff <= 4'h0;
			bytes_ff <= 2'h0;
			matched_ff <= 1'b0;
			read_ff <= 1'b0;
			shift_ff <= 8'h00;
		end
		else if (rise_ev)
		begin
			shift_ff <= {shift_ff[6:0], sda};
			bits_ff <= (bits_ff == 4'h8) ? 4'h0 : bits_ff + 4'h1;
			if (bits_ff == 4'h8 && bytes_ff != 2'h3)
				bytes_ff <= bytes_ff + 2'h1;
			if (bits_ff == 4'h8 && bytes_ff == 2'h0)
			begin
				matched_ff <= addr_hit;
				read_ff <= shift_ff[0];
			end
		end
	end

	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	sequence s_start; start_ev; endsequence
	sequence s_stop; stop_ev; endsequence
	sequence s_ack_slot; rise_ev && bits_ff == 4'h8; endsequence

	a_start_release: assert property (s_start |=> !tgt_sda_oe [*8])
		else $error("target drives data after a start");
	a_stop_release: assert property (s_stop |=> !tgt_sda_oe [*8])
		else $error("target drives data after a stop");
	a_addr_ack: assert property (
		s_ack_slot ##0 bytes_ff == 2'h0 |-> tgt_sda_oe == addr_hit)
		else $error("address acknowledge does not follow the match");
	a_write_ack: assert property (
		s_ack_slot ##0 (bytes_ff != 2'h0 && matched_ff && !read_ff) |-> tgt_sda_oe)
		else $error("written byte not acknowledged");
	a_read_slot_free: assert property (
		s_ack_slot ##0 (bytes_ff != 2'h0 && matched_ff && read_ff) |-> !tgt_sda_oe)
		else $error("target holds data in read acknowledge slot");
	a_steady_high: assert property (scl && $past(scl) |-> $stable(tgt_sda_oe))
		else $error("target data changes while clock high");
	a_addr_quiet: assert property (
		scl && bytes_ff == 2'h0 && bits_ff < 4'h8 |-> !tgt_sda_oe)
		else $error("target drives during address bits");
	a_no_contention: assert property (scl && tgt_sda_oe |-> !ctl_sda_oe)
		else $error("both ends drive data together");
	a_open_drain: assert property (
		(scl_oe || ctl_sda_oe || tgt_sda_oe) |-> !(scl_out || ctl_sda_out || tgt_sda_out))
		else $error("a link driver pushes a high level");
endmodule

// File: dv/tb.sv
// Self-checking bench: controller and target joined by one link interface.
// Software traffic goes over AXI4-Lite; the interface resolves the open-drain wires.
`timescale 1ns/1ns
module tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, latch_o;
	logic [1:0] bresp, rresp, resp, range_o, pin_lo, pin_hi;
	logic [3:0] thr_o;
	logic [7:0] avg_o;
	logic [31:0] rdata, st;
	logic [8:0] mag;
	logic new_smp = 1'b0, over = 1'b0;
	logic [6:0] addr, bad;
	logic [23:0] ctrl1, ctrl2;
	int failures = 0;
	int checked = 0;
	csi_if bus_if();

	// Both ends of the link and the wire checker
	csi_target u_csi_target (.CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_SELECT_PIN_LOW_IN(pin_lo),
		.ADDR_SELECT_PIN_HIGH_IN(pin_hi), .CURRENT_IN(mag), .NEW_SAMPLE_IN(new_smp),
		.OVERCURRENT_IN(over), .RANGE_OUT(range_o), .THRESHOLD_OUT(thr_o), .AVERAGE_OUT(avg_o),
		.LATCHED_FAULT_OUT(latch_o), .bus(bus_if));
	csi_ctrl u_csi_ctrl (.CLK_IN(clk), .RST_N_IN(rst_n), .AXI_AWADDR_IN(awaddr),
		.AXI_AWVALID_IN(awvalid), .AXI_AWREADY_OUT(awready), .AXI_WDATA_IN(wdata),
		.AXI_WSTRB_IN(wstrb), .AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(wready),
		.AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready),
		.AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready),
		.AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid),
		.AXI_RREADY_IN(rready), .bus(bus_if));
	csi_monitor u_csi_monitor (.CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_SELECT_PIN_LOW_IN(pin_lo),
		.ADDR_SELECT_PIN_HIGH_IN(pin_hi), .scl_out(bus_if.scl_out), .scl_oe(bus_if.scl_oe),
		.ctl_sda_out(bus_if.ctl_sda_out), .ctl_sda_oe(bus_if.ctl_sda_oe),
		.tgt_sda_out(bus_if.tgt_sda_out), .tgt_sda_oe(bus_if.tgt_sda_oe), .scl(bus_if.scl),
		.sda(bus_if.sda));

	// 100 MHz system clock
	always #5 clk = ~clk;

	task automatic print_verdict();
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// A wait that ran out counts as a mismatch and ends the run
	task automatic hang();
		failures++;
		print_verdict();
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One AXI4-Lite access; write offers address and data together, each dropped when taken
	task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		logic ad, w, done;
		@(posedge clk);
		{ad, w, done} = {1'b0, !wr, 1'b0};
		awaddr <= a;
		araddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		{awvalid, wvalid, bready} <= {wr, wr, wr};
		{arvalid, rready} <= {!wr, !wr};
		for (n = 0; !done; n++)
		begin
			@(posedge clk);
			if (n > 99)
				hang();
			if (ad && w && (wr ? bvalid : rvalid))
			begin
				done = 1'b1;
				resp = wr ? bresp : rresp;
				st = wr ? st : rdata;
				{bready, rready} <= 2'h0;
			end
			if ((wr ? awready : arready) && !ad)
			begin
				ad = 1'b1;
				{awvalid, arvalid} <= 2'h0;
			end
			if (wready && !w)
			begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
	endtask

	// One controller command, then poll status until the link op is over
	task automatic bus_op(input logic [1:0] op, input logic [7:0] b, input logic ak);
		int n;
		axi(1'b1, csi_pkg::AXI_CMD_OFS, {15'h0, ak, b, 6'h0, op});
		chk("cmd bresp", {30'h0, csi_pkg::RESP_OKAY}, {30'h0, resp});
		st = 32'h1;
		for (n = 0; st[0] !== 1'b0; n++)
		begin
			if (n > 2000)
				hang();
			axi(1'b0, csi_pkg::AXI_STAT_OFS, 32'h0);
		end
	endtask

	task automatic wbyte(input logic [7:0] b, input logic nak);
		bus_op(csi_pkg::OP_WRITE, b, 1'b0);
		chk("ack", {31'h0, nak}, {31'h0, st[1]});
	endtask

	task automatic rbyte(input logic ak, input logic [7:0] exp);
		bus_op(csi_pkg::OP_READ, 8'h00, ak);
		chk("read byte", {24'h0, exp}, {24'h0, st[15:8]});
	endtask

	// Register values travel most significant byte first
	task automatic wtrip(input logic [23:0] v);
		wbyte(v[23:16], 1'b0);
		wbyte(v[15:8], 1'b0);
		wbyte(v[7:0], 1'b0);
	endtask

	task automatic rtrip(input logic [23:0] v, input logic last);
		rbyte(1'b0, v[23:16]);
		rbyte(1'b0, v[15:8]);
		rbyte(last, v[7:0]);
	endtask

	task automatic open_w(input logic [7:0] ptr);
		bus_op(csi_pkg::OP_START, 8'h00, 1'b0);
		wbyte({addr, 1'b0}, 1'b0);
		wbyte(ptr, 1'b0);
	endtask

	task automatic chk_ctrl(input logic [23:0] v);
		chk("range", {30'h0, v[1:0]}, {30'h0, range_o});
		chk("threshold", {28'h0, v[5:2]}, {28'h0, thr_o});
		chk("average", {24'h0, v[13:6]}, {24'h0, avg_o});
	endtask

	// Expected data register: magnitude, then new, latched and live flags
	function automatic logic [23:0] data_word(input logic [8:0] m, input logic nw,
		input logic lt, input logic lv);
		return {12'h0, lv, lt, nw, m};
	endfunction

	// Main sequence
	initial
	begin
		void'($urandom(32'hba90));
		{pin_hi, pin_lo, mag} = 13'($urandom);
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		addr = {csi_pkg::ADDR_FIXED, pin_hi, pin_lo};
		chk_ctrl(24'h0);
		axi(1'b0, 4'h8, 32'h0);
		chk("rresp", {30'h0, csi_pkg::RESP_SLVERR}, {30'h0, resp});
		axi(1'b1, 4'hc, 32'h0);
		chk("bresp", {30'h0, csi_pkg::RESP_SLVERR}, {30'h0, resp});
		// Read-only pointer first; the second triplet must land in the next register
		ctrl1 = {10'h0, 14'($urandom)};
		open_w(csi_pkg::REG_DATA);
		wtrip(~ctrl1);
		wtrip(ctrl1);
		bus_op(csi_pkg::OP_STOP, 8'h00, 1'b0);
		chk_ctrl(ctrl1);
		// Combined read of both registers behind a repeated start
		new_smp <= 1'b1;
		over <= 1'b1;
		@(posedge clk);
		new_smp <= 1'b0;
		open_w(csi_pkg::REG_DATA);
		bus_op(csi_pkg::OP_START, 8'h00, 1'b0);
		wbyte({addr, 1'b1}, 1'b0);
		rtrip(data_word(mag, 1'b1, 1'b1, 1'b1), 1'b0);
		rtrip(ctrl1, 1'b1);
		bus_op(csi_pkg::OP_STOP, 8'h00, 1'b0);
		over <= 1'b0;
		chk("latched", 32'h1, {31'h0, latch_o});
		// Clear the latched flag, then a short group that must be dropped
		ctrl2 = {9'h0, 1'b1, 14'($urandom)};
		open_w(csi_pkg::REG_CTRL);
		wtrip(ctrl2);
		bus_op(csi_pkg::OP_STOP, 8'h00, 1'b0);
		open_w(csi_pkg::REG_CTRL);
		wbyte(~ctrl2[23:16], 1'b0);
		wbyte(~ctrl2[15:8], 1'b0);
		bus_op(csi_pkg::OP_STOP, 8'h00, 1'b0);
		chk_ctrl(ctrl2);
		chk("latched", 32'h0, {31'h0, latch_o});
		// Foreign addresses: wrong fixed bit, then wrong strap bits
		for (int i = 0; i < 2; i++)
		begin
			bad = addr ^ ((i == 0) ? 7'h40 : {3'h0, 4'($urandom_range(15, 1))});
			bus_op(csi_pkg::OP_START, 8'h00, 1'b0);
			wbyte({bad, 1'b0}, 1'b1);
			bus_op(csi_pkg::OP_STOP, 8'h00, 1'b0);
		end
		print_verdict();
	end
endmodule
